//--- design/imu_operational_control.v
`timescale 1ns/1ps
`include "imu_ctl_defs.vh"

// Notes on behaviour
// - sleep count: low byte, half-second units, resets zero
// - nonzero sleep powers down; chip-select pulse wakes
// - output data pass a Bartlett averaging filter
// - filter field M gives two-to-M taps
// - range field selects 300, 150 or 75
// - lower ranges force a minimum tap setting
// - range/filter survives software reset via flash, power-on loads default 0x0402
// - aux output code is 12 bits unsigned
// - aux output changes only on latch command
// - aux code clears on every reset
// - pin bits 1:0 set line directions
// - pin bits 9:8 drive or sense levels
// - pin control resets zero, both lines input
// - misc beats alarm beats pin control
// - misc bits enable, polarity, line of data-ready
// - bit 10 starts self-test, clears after 35 ms
// - self-test result and failing sensors in status
// - manual stimuli; accelerometers take positive only
// - bias compensation and origin alignment enables
// - flash write counter wraps after 32768 writes
module imu_operational_control #(
  parameter SLEEP_TICK_CYCLES = `SLEEP_UNIT_MS * `CLK_FREQ_KHZ,
  parameter SELF_TEST_CYCLES = `SELF_TEST_MS * `CLK_FREQ_KHZ
) (
  input wire clock,
  input wire sys_rst,
  input wire por,
  input wire cs_n,
  input wire sclk,
  input wire mosi,
  output wire miso,
  input wire io_line_one_in,
  output wire io_line_one_out,
  output wire io_line_one_oe_n,
  input wire io_line_two_in,
  output wire io_line_two_out,
  output wire io_line_two_oe_n,
  input wire data_ready,
  input wire [1:0] alarm_drive_en,
  input wire [1:0] alarm_level,
  input wire [5:0] sensor_fail,
  output wire [11:0] aux_output_level,
  output wire power_down,
  output wire sample_hold,
  output wire [2:0] range_select,
  output wire [2:0] filter_taps_log2,
  output wire gyro_stim_pos,
  output wire gyro_stim_neg,
  output wire accel_stim_pos,
  output wire accel_bias_comp,
  output wire origin_align
);

  // ************************************************************
  // functions
  // ************************************************************

  // merge one written byte into a 16-bit register
  function [15:0] put_byte;
    input [15:0] old;
    input hi;
    input [7:0] data;
    input [15:0] mask;
    begin
      if (hi) begin
        put_byte = {data, old[7:0]} & mask;
      end else begin
        put_byte = {old[15:8], data} & mask;
      end
    end
  endfunction

  // raise the tap setting to the floor of the selected range
  function [2:0] eff_taps;
    input [2:0] range;
    input [2:0] m;
    begin
      eff_taps = m;
      if (range == `RANGE_150 && m < `MIN_M_150) begin
        eff_taps = `MIN_M_150;
      end
      if (range == `RANGE_75 && m < `MIN_M_75) begin
        eff_taps = `MIN_M_75;
      end
    end
  endfunction

  // ************************************************************
  // input synchronisers
  // ************************************************************
  wire [4:0] sync_w;
  wire cs_n_s;
  wire sclk_s;
  wire mosi_s;
  wire [1:0] line_in_s;

  pin_sync3 #(
    .WIDTH(5)
  ) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({io_line_two_in, io_line_one_in, mosi, ~sclk, ~cs_n}),
    .sync_out(sync_w)
  );

  // select and link clock idle high: pass them inverted so reset lands on idle, no false edge
  assign cs_n_s = ~sync_w[0];
  assign sclk_s = ~sync_w[1];
  assign mosi_s = sync_w[2];
  assign line_in_s = sync_w[4:3];

  // ************************************************************
  // serial port
  // ************************************************************
  reg cs_p_q;
  reg sclk_p_q;
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg [3:0] bit_q;
  reg frame_q;
  reg miso_q;
  reg [15:0] rd_word;
  wire cs_rise;
  wire cs_fall;
  wire sclk_rise;
  wire sclk_fall;
  wire wr_en;
  wire rd_en;
  wire [6:0] wr_addr;
  wire [6:0] word_addr;
  wire wr_hi;
  wire [7:0] wr_data;

  assign cs_rise = ~cs_p_q & cs_n_s;
  assign cs_fall = cs_p_q & ~cs_n_s;
  assign sclk_rise = ~sclk_p_q & sclk_s & ~cs_n_s;
  assign sclk_fall = sclk_p_q & ~sclk_s & ~cs_n_s;
  assign wr_en = frame_q & rx_q[`FRAME_RW];
  assign rd_en = frame_q & ~rx_q[`FRAME_RW];
  assign wr_addr = rx_q[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  assign word_addr = {wr_addr[6:1], 1'b0};
  assign wr_hi = wr_addr[0];
  assign wr_data = rx_q[7:0];
  assign miso = miso_q;

  // shift in on rising sclk, shift out on falling sclk
  always @(posedge clock) begin
    if (sys_rst) begin
      cs_p_q <= 1'b1;
      sclk_p_q <= 1'b1;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      bit_q <= 4'h0;
      frame_q <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      cs_p_q <= cs_n_s;
      sclk_p_q <= sclk_s;
      frame_q <= 1'b0;
      if (cs_fall) begin
        bit_q <= 4'h0;
      end else if (sclk_rise) begin
        rx_q <= {rx_q[14:0], mosi_s};
        bit_q <= bit_q + 4'h1;
        frame_q <= (bit_q == `FRAME_LAST);
      end
      if (rd_en) begin
        tx_q <= rd_word;
      end else if (sclk_fall) begin
        miso_q <= tx_q[15];
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  reg [15:0] aux_q;
  reg [15:0] pin_q;
  reg [15:0] misc_q;
  reg [15:0] range_q;
  reg [15:0] sleep_q;
  reg [11:0] dac_q;
  reg [15:0] nv_range_q;
  reg [15:0] endurance_q;
  reg [5:0] st_fail_q;
  reg st_err_q;
  reg [2:0] taps_q;
  reg st_done;
  reg [31:0] st_cnt_q;
  wire cmd_wr;
  wire [15:0] st_keep;

  assign cmd_wr = wr_en & (wr_addr == `ADDR_COMMAND);
  // a running self-test survives writes of zero, but not its own completion
  assign st_keep = st_done ? 16'h0000 : (misc_q & (16'h0001 << `MISC_SELF_TEST));

  // register writes; software reset clears volatile state only
  always @(posedge clock) begin
    if (sys_rst) begin
      aux_q <= `RST_AUX;
      pin_q <= `RST_PIN;
      misc_q <= `RST_MISC;
      sleep_q <= `RST_SLEEP;
      dac_q <= 12'h000;
      range_q <= por ? `RST_RANGE : nv_range_q;
    end else begin
      if (wr_en && word_addr == `ADDR_AUX) begin
        aux_q <= put_byte(aux_q, wr_hi, wr_data, `MASK_AUX);
      end
      if (wr_en && word_addr == `ADDR_PIN) begin
        pin_q <= put_byte(pin_q, wr_hi, wr_data, `MASK_PIN);
      end
      if (wr_en && word_addr == `ADDR_RANGE) begin
        range_q <= put_byte(range_q, wr_hi, wr_data, `MASK_RANGE);
      end
      if (wr_en && word_addr == `ADDR_SLEEP) begin
        sleep_q <= put_byte(sleep_q, wr_hi, wr_data, `MASK_SLEEP);
      end
      // self-test bit: a new start wins over completion
      if (wr_en && word_addr == `ADDR_MISC) begin
        misc_q <= put_byte(misc_q, wr_hi, wr_data, `MASK_MISC) | st_keep;
      end else if (st_done) begin
        misc_q[`MISC_SELF_TEST] <= 1'b0;
      end
      // output level moves only on the latch command
      if (cmd_wr && wr_data[`CMD_DAC_LATCH]) begin
        dac_q <= aux_q[11:0];
      end
    end
  end

  // nonvolatile image and flash write count; only power-on clears them
  always @(posedge clock) begin
    if (por) begin
      nv_range_q <= `RST_RANGE;
      endurance_q <= 16'h0000;
    end else if (cmd_wr && wr_data[`CMD_FLASH]) begin
      nv_range_q <= range_q;
      if (endurance_q == `ENDURANCE_LAST) begin
        endurance_q <= 16'h0000;
      end else begin
        endurance_q <= endurance_q + 16'h0001;
      end
    end
  end

  // self-test timer and result capture
  always @(posedge clock) begin
    if (sys_rst) begin
      st_cnt_q <= 32'h00000000;
      st_done <= 1'b0;
      st_fail_q <= 6'h00;
      st_err_q <= 1'b0;
    end else begin
      st_done <= 1'b0;
      if (misc_q[`MISC_SELF_TEST] && !st_done) begin
        if (st_cnt_q == SELF_TEST_CYCLES - 1) begin
          st_cnt_q <= 32'h00000000;
          st_done <= 1'b1;
          st_fail_q <= sensor_fail;
          st_err_q <= |sensor_fail;
        end else begin
          st_cnt_q <= st_cnt_q + 32'h00000001;
        end
      end
    end
  end

  // effective tap setting handed to the averaging filter
  always @(posedge clock) begin
    if (sys_rst) begin
      taps_q <= 3'h0;
    end else begin
      taps_q <= eff_taps(range_q[10:8], range_q[2:0]);
    end
  end

  // read data; pin levels show the sensed pin for input lines
  always @* begin
    case (word_addr)
      `ADDR_ENDURANCE: rd_word = endurance_q;
      `ADDR_AUX: rd_word = aux_q;
      `ADDR_PIN: rd_word = {6'h00, pin_q[1] ? pin_q[9] : line_in_s[1],
                            pin_q[0] ? pin_q[8] : line_in_s[0], 6'h00, pin_q[1:0]};
      `ADDR_MISC: rd_word = misc_q;
      `ADDR_RANGE: rd_word = range_q;
      `ADDR_SLEEP: rd_word = sleep_q;
      `ADDR_STATUS: rd_word = {st_fail_q, 4'h0, st_err_q, 5'h00};
      default: rd_word = 16'h0000;
    endcase
  end

  // ************************************************************
  // sleep control
  // ************************************************************
  reg asleep_q;
  reg pend_q;
  reg [7:0] left_q;
  reg [31:0] tick_q;

  // sleep starts when the writing frame ends; the next cs pulse wakes
  always @(posedge clock) begin
    if (sys_rst) begin
      asleep_q <= 1'b0;
      pend_q <= 1'b0;
      left_q <= 8'h00;
      tick_q <= 32'h00000000;
    end else begin
      if (wr_en && wr_addr == `ADDR_SLEEP && wr_data != 8'h00) begin
        pend_q <= 1'b1;
      end
      if (cs_rise) begin
        pend_q <= 1'b0;
        if (asleep_q) begin
          asleep_q <= 1'b0;
        end else if (pend_q) begin
          asleep_q <= 1'b1;
          left_q <= sleep_q[7:0];
          tick_q <= 32'h00000000;
        end
      end else if (asleep_q) begin
        if (tick_q == SLEEP_TICK_CYCLES - 1) begin
          tick_q <= 32'h00000000;
          left_q <= left_q - 8'h01;
          if (left_q == 8'h01) begin
            asleep_q <= 1'b0;
          end
        end else begin
          tick_q <= tick_q + 32'h00000001;
        end
      end
    end
  end

  // ************************************************************
  // general-purpose lines
  // ************************************************************
  reg [1:0] line_out_q;
  reg [1:0] line_oe_n_q;
  wire dr_level;
  integer i;

  assign dr_level = misc_q[`MISC_DR_POL] ? data_ready : ~data_ready;

  // data-ready first, then alarm, then pin control
  always @(posedge clock) begin
    if (sys_rst) begin
      line_out_q <= 2'b00;
      line_oe_n_q <= 2'b11;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (misc_q[`MISC_DR_EN] && misc_q[`MISC_DR_SEL] == i[0]) begin
          line_out_q[i] <= dr_level;
          line_oe_n_q[i] <= 1'b0;
        end else if (alarm_drive_en[i]) begin
          line_out_q[i] <= alarm_level[i];
          line_oe_n_q[i] <= 1'b0;
        end else if (pin_q[i]) begin
          line_out_q[i] <= pin_q[`PIN_LEVEL_LSB + i];
          line_oe_n_q[i] <= 1'b0;
        end else begin
          line_out_q[i] <= 1'b0;
          line_oe_n_q[i] <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign io_line_one_out = line_out_q[0];
  assign io_line_one_oe_n = line_oe_n_q[0];
  assign io_line_two_out = line_out_q[1];
  assign io_line_two_oe_n = line_oe_n_q[1];
  assign aux_output_level = dac_q;
  assign power_down = asleep_q;
  assign sample_hold = misc_q[`MISC_SELF_TEST];
  assign range_select = range_q[10:8];
  assign filter_taps_log2 = taps_q;
  assign gyro_stim_pos = misc_q[`MISC_STIM_POS];
  assign gyro_stim_neg = misc_q[`MISC_STIM_NEG];
  assign accel_stim_pos = misc_q[`MISC_STIM_POS];
  assign accel_bias_comp = misc_q[`MISC_BIAS_COMP];
  assign origin_align = misc_q[`MISC_ORIGIN];

endmodule // imu_operational_control

//--- design/imu_ctl_defs.vh
`ifndef IMU_CTL_DEFS_VH
`define IMU_CTL_DEFS_VH

// ************************************************************
// clock and timing
// ************************************************************
`define CLK_FREQ_KHZ 200000
`define SLEEP_UNIT_MS 500
`define SELF_TEST_MS 35

// ************************************************************
// serial frame layout
// ************************************************************
`define FRAME_LAST 4'hF
`define FRAME_RW 15
`define FRAME_ADDR_HI 14
`define FRAME_ADDR_LO 8

// ************************************************************
// register byte addresses (even address = low byte)
// ************************************************************
`define ADDR_ENDURANCE 7'h00
`define ADDR_AUX 7'h30
`define ADDR_PIN 7'h32
`define ADDR_MISC 7'h34
`define ADDR_RANGE 7'h38
`define ADDR_SLEEP 7'h3A
`define ADDR_STATUS 7'h3C
`define ADDR_COMMAND 7'h3E

// ************************************************************
// reset values and writable bit masks
// ************************************************************
`define RST_AUX 16'h0000
`define RST_PIN 16'h0000
`define RST_MISC 16'h0000
`define RST_RANGE 16'h0402
`define RST_SLEEP 16'h0000
`define MASK_AUX 16'h0FFF
`define MASK_PIN 16'h0303
`define MASK_MISC 16'h07C7
`define MASK_RANGE 16'h0707
`define MASK_SLEEP 16'h00FF

// ************************************************************
// field positions
// ************************************************************
`define MISC_SELF_TEST 10
`define MISC_STIM_NEG 9
`define MISC_STIM_POS 8
`define MISC_BIAS_COMP 7
`define MISC_ORIGIN 6
`define MISC_DR_EN 2
`define MISC_DR_POL 1
`define MISC_DR_SEL 0
`define PIN_LEVEL_LSB 8
`define CMD_DAC_LATCH 2
`define CMD_FLASH 3
`define STATUS_ST_ERR 5

// ************************************************************
// range codes, tap limits and flash write count wrap point
// ************************************************************
`define RANGE_300 3'h4
`define RANGE_150 3'h2
`define RANGE_75 3'h1
`define MIN_M_150 3'h2
`define MIN_M_75 3'h4
`define ENDURANCE_LAST 16'h7FFF

`endif

//--- design/pin_sync3.v
`timescale 1ns/1ps

// ************************************************************
// three-stage input synchroniser with agreement filter
// ************************************************************
module pin_sync3 #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer i;

  // s1 feeds only s2; a change is taken when s2 and s3 agree
  always @(posedge clock) begin
    if (sys_rst) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // pin_sync3

//--- verif/imu_ctl_asserts.sv
`timescale 1ns/1ps
`include "imu_ctl_defs.vh"

// ************************************************************
// port checker
// ************************************************************
module imu_ctl_asserts #(
  parameter SLEEP_TICK_CYCLES = 20,
  parameter SELF_TEST_CYCLES = 60
) (
  input wire clock,
  input wire sys_rst,
  input wire cs_n,
  input wire io_line_one_oe_n,
  input wire io_line_two_oe_n,
  input wire [1:0] alarm_drive_en,
  input wire [11:0] aux_output_level,
  input wire power_down,
  input wire sample_hold,
  input wire [2:0] range_select,
  input wire [2:0] filter_taps_log2,
  input wire gyro_stim_pos,
  input wire accel_stim_pos
);
  reg [31:0] st_q;
  reg [31:0] pd_q;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // cycles spent in self-test and asleep
  always @(posedge clock) begin
    st_q <= (sys_rst || !sample_hold) ? 32'h0 : st_q + 32'h1;
    pd_q <= (sys_rst || !power_down) ? 32'h0 : pd_q + 32'h1;
  end
  sequence st_start;
    $rose(sample_hold);
  endsequence
  sequence st_run;
    sample_hold [*8];
  endsequence
  AST_RST_OUT: assert property ($fell(sys_rst) |-> io_line_one_oe_n && io_line_two_oe_n && aux_output_level == 12'h000)
    else $error("outputs not at reset level");
  AST_ST_HOLD: assert property (st_start |-> st_run)
    else $error("self-test dropped early");
  AST_ST_LEN: assert property (sample_hold |-> st_q <= SELF_TEST_CYCLES + 2)
    else $error("self-test ran too long");
  AST_ST_END: assert property ($fell(sample_hold) |-> $past(st_q) >= SELF_TEST_CYCLES - 1)
    else $error("self-test ended too soon");
  AST_PD_LEN: assert property (power_down |-> pd_q <= 64'h00000000000000FF * SLEEP_TICK_CYCLES + 64'h2)
    else $error("sleep exceeded largest count");
  AST_PD_CS: assert property ($rose(power_down) |-> cs_n)
    else $error("sleep began with chip select low");
  AST_FLOOR_150: assert property (range_select == `RANGE_150 && $stable(range_select) && !$past(sys_rst)
    |-> filter_taps_log2 >= `MIN_M_150)
    else $error("tap floor missing at 150");
  AST_FLOOR_75: assert property (range_select == `RANGE_75 && $stable(range_select) && !$past(sys_rst)
    |-> filter_taps_log2 >= `MIN_M_75)
    else $error("tap floor missing at 75");
  AST_STIM_ACCEL: assert property (accel_stim_pos == gyro_stim_pos)
    else $error("accel stimulus differs from positive stimulus");
  AST_ALARM_DRIVES: assert property (alarm_drive_en[0] && $past(alarm_drive_en[0]) && !$past(sys_rst)
    |-> !io_line_one_oe_n)
    else $error("claimed line not driven");
endmodule // imu_ctl_asserts

bind imu_operational_control imu_ctl_asserts #(
  .SLEEP_TICK_CYCLES(SLEEP_TICK_CYCLES),
  .SELF_TEST_CYCLES(SELF_TEST_CYCLES)
) chk (.clock, .sys_rst, .cs_n, .io_line_one_oe_n, .io_line_two_oe_n, .alarm_drive_en, .aux_output_level,
  .power_down, .sample_hold, .range_select, .filter_taps_log2, .gyro_stim_pos, .accel_stim_pos);

//--- verif/spi_host_model.sv
`timescale 1ns/1ps

// ************************************************************
// serial host: mode 3, clock still between frames
// ************************************************************
module spi_host_model (
  input wire clock,
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire miso
);
  int half = 16; // clocks per half period of the link clock
  // idle levels; select held high does not wake a sleeping device
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end
  // one 16-bit frame, msb first; r gets what came back
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(negedge clock);
    cs_n = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      repeat (half) @(negedge clock);
      sclk = 1'b0;
      mosi = w[k];
      repeat (half) @(negedge clock);
      sclk = 1'b1;
      r[k] = miso;
    end
    repeat (half) @(negedge clock);
    cs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale bit
    repeat (8) @(negedge clock);
  endtask
endmodule // spi_host_model

//--- verif/testbench.sv
`timescale 1ns/1ps
`include "imu_ctl_defs.vh"

// ************************************************************
// self-checking bench
// ************************************************************
module testbench;
  logic clock, sys_rst, por, data_ready, ext1, ext2;
  wire cs_n, sclk, mosi, miso, io_line_one_in, io_line_one_out, io_line_one_oe_n;
  wire io_line_two_in, io_line_two_out, io_line_two_oe_n;
  logic [1:0] alarm_drive_en, alarm_level;
  logic [5:0] sensor_fail;
  wire [11:0] aux_output_level;
  wire [2:0] range_select, filter_taps_log2;
  wire power_down, sample_hold, gyro_stim_pos, gyro_stim_neg, accel_stim_pos, accel_bias_comp, origin_align;
  logic [15:0] seen, d, r;
  logic [15:0] expq[$];
  logic [6:0] ra[7] = '{7'h00, 7'h10, `ADDR_AUX, `ADDR_PIN, `ADDR_MISC, `ADDR_RANGE, `ADDR_SLEEP};
  logic [15:0] rv[7] = '{16'h0000, 16'h0000, `RST_AUX, `RST_PIN, `RST_MISC, `RST_RANGE, `RST_SLEEP};
  logic [11:0] rt[4] = '{12'h212, 12'h134, 12'h400, 12'h177};
  int errors = 0;
  int samples_checked = 0;
  int i;
  event got;

  // line level seen by both parties
  assign io_line_one_in = io_line_one_oe_n ? ext1 : io_line_one_out;
  assign io_line_two_in = io_line_two_oe_n ? ext2 : io_line_two_out;

  imu_operational_control #(.SLEEP_TICK_CYCLES(20), .SELF_TEST_CYCLES(60)) uut (.clock, .sys_rst, .por, .cs_n,
    .sclk, .mosi, .miso, .io_line_one_in, .io_line_one_out, .io_line_one_oe_n, .io_line_two_in, .io_line_two_out,
    .io_line_two_oe_n, .data_ready, .alarm_drive_en, .alarm_level, .sensor_fail, .aux_output_level, .power_down,
    .sample_hold, .range_select, .filter_taps_log2, .gyro_stim_pos, .gyro_stim_neg, .accel_stim_pos,
    .accel_bias_comp, .origin_align);
  spi_host_model host (.clock, .cs_n, .sclk, .mosi, .miso);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watcher: each shown result meets the oldest note
  always @(got) check(seen, expq.pop_front());
  task automatic note(input logic [15:0] e);
    expq.push_back(e);
  endtask
  task automatic show(input logic [15:0] s);
    seen = s;
    -> got;
    @(negedge clock);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    host.xfer({1'b1, a, v}, r);
  endtask
  // read returns in the following frame
  task automatic rdc(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] q;
    note(e);
    host.xfer({1'b0, a, 8'h00}, r);
    host.xfer(16'h0000, q);
    show(q);
  endtask
  task automatic wait_clear(input bit sel);
    for (i = 0; i < 300 && (sel ? power_down : sample_hold) !== 1'b0; i++) @(negedge clock);
    if (i == 300) begin
      errors++;
      close_out;
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    por = 1'b1;
    {data_ready, ext1, ext2, alarm_drive_en, alarm_level, sensor_fail} = '0;
    d = $urandom(53693);
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    por = 1'b0;
    repeat (4) @(negedge clock);
    for (int k = 0; k < 7; k++) rdc(ra[k], rv[k]);
    note(16'h0009); show({aux_output_level, range_select, io_line_one_oe_n});
    wr(7'h00, 8'h55);
    rdc(7'h00, 16'h0000);
    // aux code: bytes alone leave the output, latch moves it
    d = $urandom;
    wr(`ADDR_AUX, d[7:0]);
    wr(`ADDR_AUX + 7'h01, d[15:8]);
    note(16'h0000); show({4'h0, aux_output_level});
    rdc(`ADDR_AUX, d & `MASK_AUX);
    wr(`ADDR_COMMAND, 8'h04);
    note(d & `MASK_AUX); show({4'h0, aux_output_level});
    // range first, then taps; floor applied to effective taps
    for (int k = 0; k < 4; k++) begin
      wr(`ADDR_RANGE + 7'h01, {5'h00, rt[k][10:8]});
      wr(`ADDR_RANGE, {5'h00, rt[k][6:4]});
      rdc(`ADDR_RANGE, {5'h00, rt[k][10:8], 5'h00, rt[k][6:4]});
      note({10'h000, rt[k][10:8], rt[k][2:0]}); show({10'h000, range_select, filter_taps_log2});
    end
    wr(`ADDR_COMMAND, 8'h08);
    rdc(7'h00, 16'h0001);
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    rdc(`ADDR_RANGE, 16'h0107);
    rdc(`ADDR_AUX, 16'h0000);
    // lines: pin control, then alarm claim, then data-ready
    ext1 = $urandom;
    wr(`ADDR_PIN, 8'h02);
    wr(`ADDR_PIN + 7'h01, 8'h02);
    note(16'h0003); show({13'h0, io_line_two_oe_n, io_line_two_out, io_line_one_oe_n});
    rdc(`ADDR_PIN, {7'h01, ext1, 8'h02});
    alarm_drive_en = 2'b01;
    alarm_level = 2'b01;
    repeat (2) @(negedge clock);
    note(16'h0001); show({14'h0, io_line_one_oe_n, io_line_one_out});
    wr(`ADDR_MISC, 8'hC6);
    wr(`ADDR_MISC + 7'h01, 8'h03);
    note(16'h0000); show({14'h0, io_line_one_oe_n, io_line_one_out});
    data_ready = 1'b1;
    repeat (2) @(negedge clock);
    note(16'h0001); show({14'h0, io_line_one_oe_n, io_line_one_out});
    wr(`ADDR_MISC, 8'hC5);
    note(16'h0004); show({12'h0, io_line_one_oe_n, io_line_one_out, io_line_two_oe_n, io_line_two_out});
    note(16'h001F); show({11'h0, gyro_stim_neg, gyro_stim_pos, accel_stim_pos, accel_bias_comp, origin_align});
    rdc(`ADDR_MISC, 16'h03C5);
    alarm_drive_en = 2'b00;
    // internal self-test with random failing sensors
    sensor_fail = $urandom;
    wr(`ADDR_MISC + 7'h01, 8'h04);
    note(16'h0001); show({15'h0, sample_hold});
    wait_clear(1'b0);
    rdc(`ADDR_STATUS, {sensor_fail, 4'h0, |sensor_fail, 5'h00});
    rdc(`ADDR_MISC, 16'h00C5);
    // sleep: upper byte unused, two units run out with no chip-select pulse
    wr(`ADDR_SLEEP + 7'h01, 8'hFF);
    rdc(`ADDR_SLEEP, 16'h0000);
    wr(`ADDR_SLEEP, 8'h02);
    wait_clear(1'b1);
    note(16'h0001); show({15'h0, (i >= 30 && i <= 40)});
    // longest count, so only the chip-select pulse can end it within the next frame
    wr(`ADDR_SLEEP, 8'hFF);
    note(16'h0001); show({15'h0, power_down});
    host.xfer(16'h0000, r);
    note(16'h0000); show({15'h0, power_down});
    close_out;
  end
endmodule // testbench
